/* File: freeze_mode_pad_control.sv */
// Freeze mode decision, pad control and AXI4-Lite register slave.
// Assumes request pin and pad inputs are asynchronous; core signals use aclk.
//
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`default_nettype none
module freeze_mode_pad_control
  import freeze_pkg::*;
#(
  parameter int PADS = freeze_pkg::NUM_PADS
) (
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire logic            freeze_request_pin,
  input  wire logic            user_freeze_gate,
  input  wire logic [PADS-1:0] core_out,
  input  wire logic [PADS-1:0] core_oe_n,
  input  wire logic [PADS-1:0] pad_in,
  output logic      [PADS-1:0] pad_out,
  output logic      [PADS-1:0] pad_oe_n,
  output logic      [PADS-1:0] pad_pull_en,
  output logic      [PADS-1:0] pad_pull_up,
  output logic      [PADS-1:0] core_in,
  output logic                 frozen,
  input  wire logic [11:0]     s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  input  wire logic [11:0]     s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready
);
  import freeze_pkg::*;

  // Pad words must fit one 32-bit register
  if (PADS < 1 || PADS > 32) begin : g_bad_pads
    $error("PADS must be 1 to 32");
  end

  // Pin and pad inputs cross into aclk
  logic            req_s1_q, req_s2_q;
  logic [PADS-1:0] pad_s1_q, pad_s2_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      pad_s1_q <= '0;
      pad_s2_q <= '0;
    end else begin
      req_s1_q <= freeze_request_pin;
      req_s2_q <= req_s1_q;
      pad_s1_q <= pad_in;
      pad_s2_q <= pad_s1_q;
    end
  end

  // Register state
  logic            mode2_q, mode2_d;
  logic [PADS-1:0] pull_en_q, pull_en_d, pull_up_q, pull_up_d;
  logic            frozen_q, frozen_d;
  logic            aw_q, aw_d, w_q, w_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [11:0]     awaddr_q, awaddr_d;
  logic [31:0]     wdata_q, wdata_d, rdata_q, rdata_d;
  logic [1:0]      bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]     pad_word;

  always_comb begin
    pad_word = '0;
    pad_word[PADS-1:0] = pull_en_q;
  end

  // Freeze decision
  always_comb begin
    if (mode2_q) begin
      frozen_d = req_s2_q & user_freeze_gate; // RQ2 RQ7
    end else begin
      frozen_d = req_s2_q; // RQ1 RQ7
    end
  end

  always_comb begin
    mode2_d   = mode2_q;
    pull_en_d = pull_en_q;
    pull_up_d = pull_up_q;
    aw_d      = aw_q;
    w_d       = w_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_d     = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_d     = 1'b1;
      wdata_d = s_axi_wdata;
    end
    if (aw_q && w_q && !bvalid_q) begin
      aw_d     = 1'b0;
      w_d      = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = RESP_OKAY;
      case ({awaddr_q[11:2], 2'b00})
        CTRL_OFFSET: begin
          mode2_d = wdata_q[MODE_BIT];
        end
        PULL_OFFSET: begin
          pull_en_d = wdata_q[PADS-1:0];
        end
        PULLUP_OFFSET: begin
          pull_up_d = wdata_q[PADS-1:0];
        end
        STATUS_OFFSET: begin
          bresp_d = RESP_OKAY;
        end
        default: begin
          bresp_d = RESP_SLVERR;
        end
      endcase
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      rdata_d  = '0;
      case ({s_axi_araddr[11:2], 2'b00})
        CTRL_OFFSET: begin
          rdata_d[MODE_BIT] = mode2_q;
        end
        STATUS_OFFSET: begin
          rdata_d[FROZEN_BIT] = frozen_q;
          rdata_d[PIN_BIT]    = req_s2_q;
          rdata_d[GATE_BIT]   = user_freeze_gate;
        end
        PULL_OFFSET: begin
          rdata_d = pad_word;
        end
        PULLUP_OFFSET: begin
          rdata_d[PADS-1:0] = pull_up_q;
        end
        default: begin
          rresp_d = RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode2_q   <= MODE_RESET;
      pull_en_q <= '0;
      pull_up_q <= '0;
      frozen_q  <= 1'b0;
      aw_q      <= 1'b0;
      w_q       <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
    end else begin
      mode2_q   <= mode2_d;
      pull_en_q <= pull_en_d;
      pull_up_q <= pull_up_d;
      frozen_q  <= frozen_d;
      aw_q      <= aw_d;
      w_q       <= w_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  // Address and data each held until the write completes
  assign s_axi_awready = !aw_q && !bvalid_q;
  assign s_axi_wready  = !w_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign frozen        = frozen_q;

  // Request pin has no pull cell; keeping it clean is the board's job
  genvar i;
  generate
    for (i = 0; i < PADS; i++) begin : g_pad
      pad_freeze_cell u_cell (
        .frozen      (frozen_q),
        .pull_en     (pull_en_q[i]),
        .pull_up     (pull_up_q[i]),
        .core_out    (core_out[i]),
        .core_oe_n   (core_oe_n[i]),
        .pad_in      (pad_s2_q[i]),
        .pad_out     (pad_out[i]),
        .pad_oe_n    (pad_oe_n[i]),
        .pad_pull_en (pad_pull_en[i]),
        .pad_pull_up (pad_pull_up[i]),
        .core_in     (core_in[i])
      );
    end
  endgenerate

  type1_entry_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !mode2_q && $stable(mode2_q) ##0 req_s2_q |=> frozen_q) // RQ1
    else $error("type 1 did not freeze on request");
  type2_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    mode2_q && !user_freeze_gate |=> !frozen_q) // RQ2
    else $error("type 2 froze without gate");
  type2_both_a: assert property (@(posedge aclk) disable iff (!aresetn)
    mode2_q && req_s2_q && user_freeze_gate |=> frozen_q) // RQ2
    else $error("type 2 did not freeze with pin and gate");
  pad_tristate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    frozen_q |-> pad_oe_n == {PADS{1'b1}}) // RQ3
    else $error("pad driven while frozen");
  pull_kept_a: assert property (@(posedge aclk) disable iff (!aresetn)
    frozen_q |-> pad_pull_en == pull_en_q && pad_pull_up == pull_up_q) // RQ4
    else $error("weak pull lost while frozen");
  core_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
    frozen_q |-> core_in == {PADS{1'b1}}) // RQ5
    else $error("core input not High while frozen");
  freeze_exit_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !req_s2_q |=> !frozen_q ##0 core_in == pad_s2_q) // RQ7
    else $error("freeze held after request dropped");
  write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    aw_q && w_q && !bvalid_q |=> bvalid_q)
    else $error("write response missing");
endmodule
`default_nettype wire

/* File: freeze_pkg.sv */
// Constants for the freeze mode pad control block.
// Assumes a single 20 MHz clock and an AXI4-Lite master on the register side.
// How it works
// RQ1: Type 1: freeze follows request pin only.
// RQ2: Type 2: freeze needs pin and gate.
// RQ3: Frozen unpulled pads go high impedance.
// RQ4: Frozen pulled pads show their weak pull.
// RQ5: Frozen core inputs read constant High.
// RQ6: Request pin must carry no weak pull.
// RQ7: Freeze ends when entry condition drops.
`default_nettype none
package freeze_pkg;
  localparam int          NUM_PADS      = 8;
  localparam logic [11:0] CTRL_OFFSET   = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam logic [11:0] PULL_OFFSET   = 12'h008;
  localparam logic [11:0] PULLUP_OFFSET = 12'h00C;
  localparam int          MODE_BIT      = 0;
  localparam int          FROZEN_BIT    = 0;
  localparam int          PIN_BIT       = 1;
  localparam int          GATE_BIT      = 2;
  localparam logic        MODE_RESET    = 1'b0;
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;
endpackage
`default_nettype wire

/* File: pad_freeze_cell.sv */
// One pad's freeze behaviour: output gating and core input forcing.
// Assumes freeze is a registered level from the same clock.
`default_nettype none
module pad_freeze_cell (
  input  wire logic frozen,
  input  wire logic pull_en,
  input  wire logic pull_up,
  input  wire logic core_out,
  input  wire logic core_oe_n,
  input  wire logic pad_in,
  output logic      pad_out,
  output logic      pad_oe_n,
  output logic      pad_pull_en,
  output logic      pad_pull_up,
  output logic      core_in
);
  // Output enable ignored while frozen
  assign pad_oe_n    = frozen ? 1'b1 : core_oe_n; // RQ3
  assign pad_out     = core_out;
  // Weak pull stays configured, never driven
  assign pad_pull_en = pull_en; // RQ4
  assign pad_pull_up = pull_up; // RQ4
  assign core_in     = frozen ? 1'b1 : pad_in; // RQ5
endmodule
`default_nettype wire

/* File: freeze_partner.sv */
// Far side model: request pin driver and user core gate logic.
// Assumes the bench asks for levels; both change just after aclk rises.
`default_nettype none
module freeze_partner (
  input  wire logic aclk,
  input  wire logic want_pin,
  input  wire logic want_gate,
  output logic      freeze_request_pin,
  output logic      user_freeze_gate
);
  timeunit 1ns;
  timeprecision 1ns;
  // Driven hard at all times, never left to a weak pull
  always @(posedge aclk) freeze_request_pin <= want_pin;
  always @(posedge aclk) user_freeze_gate <= want_gate;
endmodule
`default_nettype wire

/* File: freeze_mode_pad_control_tb.sv */
// Self-checking bench for the freeze mode pad control block.
// Assumes the partner model in its own file and the freeze package.
`default_nettype none
module freeze_mode_pad_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import freeze_pkg::*;
  typedef struct packed {logic m, p, g; logic [7:0] pe, pu; logic f;} row_t;
  logic        aclk, aresetn, want_pin, want_gate;
  logic [7:0]  core_out, core_oe_n, pad_in, rd;
  wire  [7:0]  pad_out, pad_oe_n, pad_pull_en, pad_pull_up, core_in;
  wire         frozen, freeze_request_pin, user_freeze_gate;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  logic [1:0]  resp;
  int          fails, samples_checked;
  // Exit rows follow freeze rows so release is seen too
  row_t rows [7] = '{
    '{1'b0, 1'b1, 1'b0, 8'h00, 8'h00, 1'b1},
    '{1'b0, 1'b0, 1'b1, 8'h00, 8'h00, 1'b0},
    '{1'b0, 1'b1, 1'b1, 8'hA5, 8'h0F, 1'b1},
    '{1'b1, 1'b1, 1'b0, 8'hA5, 8'h0F, 1'b0},
    '{1'b1, 1'b0, 1'b1, 8'h3C, 8'hF0, 1'b0},
    '{1'b1, 1'b1, 1'b1, 8'h3C, 8'hF0, 1'b1},
    '{1'b1, 1'b0, 1'b0, 8'hFF, 8'h00, 1'b0}};

  freeze_mode_pad_control #(.PADS(NUM_PADS)) freeze_mode_pad_control_inst (
    .aclk, .aresetn, .freeze_request_pin, .user_freeze_gate, .core_out, .core_oe_n,
    .pad_in, .pad_out, .pad_oe_n, .pad_pull_en, .pad_pull_up, .core_in, .frozen,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);

  freeze_partner freeze_partner_inst (
    .aclk, .want_pin, .want_gate, .freeze_request_pin, .user_freeze_gate);

  always #25 aclk = ~aclk;

  task automatic end_of_test();
    if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Both halves offered together, each dropped once taken
  task automatic axi_write(input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    // One idle edge so bready is never lowered and raised in one step
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (s_axi_bvalid !== 1'b1) begin
      fails++;
      end_of_test();
    end
  endtask

  task automatic axi_read(input logic [11:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    rd = s_axi_rdata[7:0];
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (s_axi_rvalid !== 1'b1) begin
      fails++;
      end_of_test();
    end
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    end_of_test();
  end

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {want_pin, want_gate} = 2'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    s_axi_wstrb = 4'hF;
    core_out = 8'h96;
    core_oe_n = 8'h5A;
    pad_in = 8'hC3;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 7; i++) begin
      axi_write(CTRL_OFFSET, {7'h00, rows[i].m});
      axi_write(PULL_OFFSET, rows[i].pe);
      axi_write(PULLUP_OFFSET, rows[i].pu);
      check("bresp", {6'h00, resp}, {6'h00, RESP_OKAY});
      want_pin <= rows[i].p;
      want_gate <= rows[i].g;
      // One partner flop plus three cycles of sync and state
      repeat (6) @(posedge aclk);
      check("frozen", {7'h00, frozen}, {7'h00, rows[i].f});
      check("pad_oe_n", pad_oe_n, rows[i].f ? 8'hFF : core_oe_n);
      check("core_in", core_in, rows[i].f ? 8'hFF : pad_in);
      check("pull_en", pad_pull_en, rows[i].pe);
      check("pull_up", pad_pull_up, rows[i].pu);
      check("pad_out", pad_out, core_out);
      axi_read(STATUS_OFFSET);
      check("status", rd, {5'h00, rows[i].g, rows[i].p, rows[i].f});
      check("rresp", {6'h00, resp}, {6'h00, RESP_OKAY});
      axi_read(PULL_OFFSET);
      check("pull_rd", rd, rows[i].pe);
    end
    axi_read(12'h010);
    check("rresp", {6'h00, resp}, {6'h00, RESP_SLVERR});
    check("rdata", rd, 8'h00);
    axi_write(12'h010, 8'h01);
    check("bresp", {6'h00, resp}, {6'h00, RESP_SLVERR});
    axi_read(CTRL_OFFSET);
    check("ctrl", rd, 8'h01);
    // Reset while frozen, pin then kept high into type 1
    want_pin <= 1'b1;
    want_gate <= 1'b1;
    repeat (6) @(posedge aclk);
    check("frozen", {7'h00, frozen}, 8'h01);
    aresetn <= 1'b0;
    want_gate <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check("frozen", {7'h00, frozen}, 8'h00);
    check("pull_en", pad_pull_en, 8'h00);
    axi_read(CTRL_OFFSET);
    check("ctrl", rd, {7'h00, MODE_RESET});
    repeat (6) @(posedge aclk);
    check("frozen", {7'h00, frozen}, 8'h01);
    check("core_in", core_in, 8'hFF);
    end_of_test();
  end
endmodule
`default_nettype wire
